// ==== hdl/oag_addr_gen.sv ====
// Operand effective address generator with banked registers
// Contract
// RULE1: Multiply accumulator by auxiliary byte into accumulator pair
// RULE2: Register chosen from bank flags plus code
// RULE3: Three opcode bits pick one byte register
// RULE4: Eight byte registers, four pairs per bank
// RULE5: Direct mode uses 16-bit immediate unchanged
// RULE6: Short direct reaches only FE20H to FF1FH
// RULE7: Bit 8 set when immediate below 20H
// RULE8: Short direct bits 15 to 9 all ones
// RULE9: RAM FE20H-FEFFH, registers FF00H-FF1FH in window
// RULE10: Word short direct operand must be even
// RULE11: Register page reaches FF00H-FFCFH and FFE0H-FFFFH
// RULE12: Register page address is FF00H plus immediate
// RULE13: Word register page operand must be even
// RULE14: Indirect uses selected pair of current bank
// RULE15: Opcode 85H loads accumulator through pointer pair
// RULE16: Base pair plus zero-extended immediate, carry dropped
// RULE17: Base pair plus zero-extended index, carry dropped
// RULE18: Opcode ABH loads accumulator from base plus high
// RULE19: Stack accesses go through the stack pointer
// RULE20: Stack must stay inside high-speed RAM
// RULE21: Opcode B5H pushes pointer pair on stack
`timescale 1ns/100ps
module oag_addr_gen import oag_pkg::*; (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Bank select flags
    input wire logic bank_select_bit_low,
    input wire logic bank_select_bit_high,
    // Operand request
    input wire logic req_valid,
    input wire oag_mode_e req_mode,
    input wire logic req_word,
    input wire logic [7:0] imm8,
    input wire logic [15:0] full_address_operand,
    input wire logic [2:0] reg_code,
    input wire logic [1:0] pair_code,
    input wire logic index_high_sel,
    // Fixed operation code decode
    input wire logic op_valid,
    input wire logic [7:0] op_byte,
    // Stack pointer contents
    input wire logic [15:0] stack_pointer,
    // Register writes from the execution unit
    input wire logic byte_wr_en,
    input wire logic [2:0] byte_wr_code,
    input wire logic [7:0] byte_wr_data,
    input wire logic pair_wr_en,
    input wire logic [1:0] pair_wr_code,
    input wire logic [15:0] pair_wr_data,
    // Effective address result
    output logic ea_valid,
    output logic [15:0] ea,
    output logic ea_word,
    output logic area_hiram,
    output logic area_sfr,
    output logic range_err,
    output logic align_err,
    output logic stack_ram_err,
    // Register operands and status
    output logic [7:0] rd_byte,
    output logic [15:0] rd_pair,
    output logic op_hit,
    output logic mul_done
);
    logic [1:0] bank;
    logic hit_ld_de;
    logic hit_ld_hlb;
    logic hit_push_de;
    logic op_hit_now;
    logic fire;
    oag_mode_e eff_mode;
    logic [1:0] eff_pair;
    logic eff_idx_high;
    logic eff_word;
    logic [7:0] rf_byte;
    logic [15:0] rf_pair;
    logic [15:0] base_pair;
    logic [7:0] idx_high;
    logic [7:0] idx_low;
    logic [7:0] acc;
    logic [7:0] aux;
    logic [15:0] acc_pair;
    logic [15:0] product;
    logic mul_fire;
    logic rf_pair_wr;
    logic [1:0] rf_pair_code;
    logic [15:0] rf_pair_data;
    logic [7:0] idx_sel;
    logic [15:0] short_ea;
    logic [15:0] sfr_ea;
    logic [15:0] based_ea;
    logic [15:0] idx_ea;
    logic [15:0] push_ea;
    logic [15:0] next_ea;
    logic next_has_ea;
    logic next_hiram;
    logic next_sfr;
    logic next_range_err;
    logic next_align_err;
    logic next_stack_err;
    logic is_stack;
    logic is_even_form;

    // Bank from the two select flags
    assign bank = {bank_select_bit_high, bank_select_bit_low}; // [RULE2]

    // Fixed operation code decode, wins over a plain request
    assign hit_ld_de = op_valid && (op_byte == OP_LOAD_ACC_DE); // [RULE15]
    assign hit_ld_hlb = op_valid && (op_byte == OP_LOAD_ACC_HL_B); // [RULE18]
    assign hit_push_de = op_valid && (op_byte == OP_PUSH_DE); // [RULE21]
    assign op_hit_now = hit_ld_de | hit_ld_hlb | hit_push_de;
    assign fire = op_hit_now | req_valid;

    // Effective request after decode
    assign eff_mode = hit_ld_de ? MODE_REG_IND : // [RULE15]
                      hit_ld_hlb ? MODE_BASED_IDX : // [RULE18]
                      hit_push_de ? MODE_PUSH : req_mode; // [RULE21]
    assign eff_pair = (hit_ld_de | hit_push_de) ? PAIR_DE : pair_code;
    assign eff_idx_high = hit_ld_hlb | (!op_hit_now & index_high_sel); // [RULE18]
    assign eff_word = hit_push_de | (!op_hit_now & req_word);

    // Multiply writes the product into the accumulator pair
    assign mul_fire = fire && (eff_mode == MODE_UNSIGNED_MULTIPLY_OP); // [RULE1]
    assign rf_pair_wr = mul_fire | pair_wr_en;
    assign rf_pair_code = mul_fire ? PAIR_ACC : pair_wr_code; // [RULE1]
    assign rf_pair_data = mul_fire ? product : pair_wr_data; // [RULE1]

    // Banked general registers
    oag_regfile u_regs (
        .clk_sys(clk_sys),
        .reset(reset),
        .bank(bank),
        .rd_code(reg_code),
        .rd_pair_code(eff_pair),
        .byte_wr_en(byte_wr_en),
        .byte_wr_code(byte_wr_code),
        .byte_wr_data(byte_wr_data),
        .pair_wr_en(rf_pair_wr),
        .pair_wr_code(rf_pair_code),
        .pair_wr_data(rf_pair_data),
        .rd_byte(rf_byte),
        .rd_pair(rf_pair),
        .base_pair(base_pair),
        .idx_high(idx_high),
        .idx_low(idx_low),
        .acc(acc),
        .aux(aux),
        .acc_pair(acc_pair)
    );

    // Implied multiply operands, no operand field
    oag_mul8 #(
        .WIDTH(8)
    ) u_mul (
        .multiplicand(acc),
        .multiplier(aux),
        .product(product)
    );

    // Candidate addresses per mode
    assign short_ea = {SHORT_TOP_BITS, imm8 < SHORT_LOW_LIMIT, imm8}; // [RULE6] [RULE7] [RULE8]
    assign sfr_ea = {SFR_PAGE, imm8}; // [RULE12]
    assign based_ea = base_pair + {8'h00, imm8}; // [RULE16]
    assign idx_sel = eff_idx_high ? idx_high : idx_low;
    assign idx_ea = base_pair + {8'h00, idx_sel}; // [RULE17]
    assign push_ea = stack_pointer - STACK_WORD_BYTES; // [RULE19]

    // Address selection by mode
    always_comb begin
        next_ea = 16'h0000;
        next_has_ea = 1'b1;
        case (eff_mode)
            MODE_DIRECT: next_ea = full_address_operand; // [RULE5]
            MODE_SHORT: next_ea = short_ea; // [RULE6]
            MODE_SFR: next_ea = sfr_ea; // [RULE11]
            MODE_REG_IND: next_ea = rf_pair; // [RULE14]
            MODE_BASED: next_ea = based_ea; // [RULE16]
            MODE_BASED_IDX: next_ea = idx_ea; // [RULE17]
            MODE_PUSH: next_ea = push_ea; // [RULE19]
            MODE_POP: next_ea = stack_pointer; // [RULE19]
            MODE_REGISTER: next_has_ea = 1'b0;
            MODE_UNSIGNED_MULTIPLY_OP: next_has_ea = 1'b0;
            default: next_has_ea = 1'b0;
        endcase
    end

    // Area and error classification
    assign is_stack = (eff_mode == MODE_PUSH) || (eff_mode == MODE_POP);
    assign is_even_form = (eff_mode == MODE_SHORT) || (eff_mode == MODE_SFR) || is_stack;
    assign next_hiram = (next_ea >= HIRAM_LO) && (next_ea <= HIRAM_HI); // [RULE9]
    assign next_sfr = next_ea >= SFR_LO; // [RULE9]
    assign next_range_err = (eff_mode == MODE_SFR) && (imm8[7:4] == SFR_HOLE_NIBBLE); // [RULE11] [RULE12]
    assign next_align_err = is_even_form && eff_word && next_ea[0]; // [RULE10] [RULE13]
    assign next_stack_err = is_stack && !(next_hiram && (!eff_word || next_ea != HIRAM_HI)); // [RULE20]

    // Address outputs
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ea_valid <= 1'b0;
            ea <= 16'h0000;
            ea_word <= 1'b0;
        end else begin
            ea_valid <= fire && next_has_ea;
            ea <= fire ? next_ea : ea;
            ea_word <= fire ? (eff_word && next_has_ea) : ea_word;
        end
    end

    // Area and error flags, one per request
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            area_hiram <= 1'b0;
            area_sfr <= 1'b0;
            range_err <= 1'b0;
            align_err <= 1'b0;
            stack_ram_err <= 1'b0;
        end else begin
            area_hiram <= fire && next_has_ea && next_hiram;
            area_sfr <= fire && next_has_ea && next_sfr;
            range_err <= fire && next_range_err;
            align_err <= fire && next_align_err;
            stack_ram_err <= fire && next_stack_err;
        end
    end

    // Register operands, decode hit and multiply completion
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rd_byte <= 8'h00;
            rd_pair <= 16'h0000;
            op_hit <= 1'b0;
            mul_done <= 1'b0;
        end else begin
            rd_byte <= fire ? rf_byte : rd_byte; // [RULE3]
            rd_pair <= fire ? rf_pair : rd_pair; // [RULE2]
            op_hit <= op_hit_now;
            mul_done <= mul_fire; // [RULE1]
        end
    end

    // Checks of the address generator
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    chk_mul_product: assert property ( // [RULE1]
        mul_fire |=> (mul_done && acc_pair == 16'({8'h00, $past(acc)} * {8'h00, $past(aux)})))
        else $error("multiply product not in accumulator pair");

    chk_direct_pass: assert property ( // [RULE5]
        (fire && eff_mode == MODE_DIRECT) |=> (ea_valid && ea == $past(full_address_operand)))
        else $error("direct address altered");

    chk_short_window: assert property ( // [RULE6]
        (fire && eff_mode == MODE_SHORT) |=> (ea >= HIRAM_LO && ea <= 16'hff1f))
        else $error("short direct address outside window");

    chk_short_bit_eight: assert property ( // [RULE7]
        (fire && eff_mode == MODE_SHORT) |=> (ea[8] == ($past(imm8) < 8'h20) && ea[7:0] == $past(imm8)))
        else $error("short direct bit 8 wrong");

    chk_short_area: assert property ( // [RULE9]
        (fire && eff_mode == MODE_SHORT) |=> (area_hiram != area_sfr))
        else $error("short direct area flags wrong");

    chk_sfr_hole: assert property ( // [RULE12]
        (fire && eff_mode == MODE_SFR) |=> (ea[15:8] == 8'hff && range_err == (ea[7:4] == 4'hd)))
        else $error("register page address or hole flag wrong");

    chk_word_align: assert property ( // [RULE13]
        (fire && eff_mode == MODE_SFR && eff_word && imm8[0]) |=> align_err)
        else $error("odd word register address not flagged");

    chk_based_sum: assert property ( // [RULE16]
        (fire && eff_mode == MODE_BASED) |=> (ea == 16'($past(base_pair) + {8'h00, $past(imm8)})))
        else $error("based address sum wrong");

    chk_op_load_de: assert property ( // [RULE15]
        hit_ld_de |=> (op_hit && ea_valid && ea == $past(rf_pair)))
        else $error("load through pointer pair misaddressed");

    chk_op_load_hlb: assert property ( // [RULE18]
        hit_ld_hlb |=> (ea == 16'($past(base_pair) + {8'h00, $past(idx_high)})))
        else $error("load from base plus high index misaddressed");

    chk_op_push_de: assert property ( // [RULE21]
        hit_push_de |=> (ea_word && ea == 16'($past(stack_pointer) - 16'h0002)))
        else $error("push of pointer pair misaddressed");

    chk_stack_ram: assert property ( // [RULE20]
        (fire && eff_mode == MODE_POP && (stack_pointer < HIRAM_LO)) |=> stack_ram_err)
        else $error("stack outside high-speed RAM not flagged");

    cov_short_sfr_part: cover property (fire && eff_mode == MODE_SHORT && imm8 < SHORT_LOW_LIMIT);
    cov_based_carry: cover property (fire && eff_mode == MODE_BASED && based_ea < base_pair);
    cov_push_then_pop: cover property (hit_push_de ##1 (fire && eff_mode == MODE_POP));
    cov_multiply: cover property (mul_fire ##1 mul_done);
endmodule

// ==== hdl/oag_pkg.sv ====
// Shared constants and types for the operand address generator
package oag_pkg;
    // Addressing modes carried by a request
    typedef enum logic [3:0] {
        MODE_REGISTER,
        MODE_DIRECT,
        MODE_SHORT,
        MODE_SFR,
        MODE_REG_IND,
        MODE_BASED,
        MODE_BASED_IDX,
        MODE_PUSH,
        MODE_POP,
        MODE_UNSIGNED_MULTIPLY_OP
    } oag_mode_e;

    // Byte register codes inside one bank
    localparam logic [2:0] REG_X = 3'h0;
    localparam logic [2:0] REG_A = 3'h1;
    localparam logic [2:0] REG_C = 3'h2;
    localparam logic [2:0] REG_B = 3'h3;
    // Register pair codes inside one bank
    localparam logic [1:0] PAIR_ACC = 2'h0;
    localparam logic [1:0] PAIR_DE = 2'h2;
    localparam logic [1:0] PAIR_HL = 2'h3;
    // Register file shape
    localparam int REG_BANKS = 4;
    localparam int REGS_PER_BANK = 8;
    localparam logic [7:0] REG_RESET = 8'h00;

    // Short direct window
    localparam logic [6:0] SHORT_TOP_BITS = 7'h7f;
    localparam logic [7:0] SHORT_LOW_LIMIT = 8'h20;
    // Special function register page
    localparam logic [7:0] SFR_PAGE = 8'hff;
    localparam logic [3:0] SFR_HOLE_NIBBLE = 4'hd;
    localparam logic [15:0] SFR_LO = 16'hff00;
    // Internal high-speed RAM
    localparam logic [15:0] HIRAM_LO = 16'hfe20;
    localparam logic [15:0] HIRAM_HI = 16'hfeff;
    // Stack step for one pair
    localparam logic [15:0] STACK_WORD_BYTES = 16'h0002;

    // Fixed operation codes
    localparam logic [7:0] OP_LOAD_ACC_DE = 8'h85;
    localparam logic [7:0] OP_LOAD_ACC_HL_B = 8'hab;
    localparam logic [7:0] OP_PUSH_DE = 8'hb5;
endpackage

// ==== hdl/oag_mul8.sv ====
// Unsigned 8 by 8 multiplier
`timescale 1ns/100ps
module oag_mul8 #(
    parameter int WIDTH = 8
) (
    // Operands
    input wire logic [WIDTH-1:0] multiplicand,
    input wire logic [WIDTH-1:0] multiplier,
    // Full width product
    output logic [2*WIDTH-1:0] product
);
    // Zero-extend both sides so no bits are lost
    assign product = {{WIDTH{1'b0}}, multiplicand} * {{WIDTH{1'b0}}, multiplier};
endmodule

// ==== hdl/oag_regfile.sv ====
// Banked general register file, four banks of eight bytes
`timescale 1ns/100ps
module oag_regfile import oag_pkg::*; (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Current bank
    input wire logic [1:0] bank,
    // Read selects
    input wire logic [2:0] rd_code,
    input wire logic [1:0] rd_pair_code,
    // Byte write
    input wire logic byte_wr_en,
    input wire logic [2:0] byte_wr_code,
    input wire logic [7:0] byte_wr_data,
    // Pair write, wins over a byte write
    input wire logic pair_wr_en,
    input wire logic [1:0] pair_wr_code,
    input wire logic [15:0] pair_wr_data,
    // Read data
    output logic [7:0] rd_byte,
    output logic [15:0] rd_pair,
    output logic [15:0] base_pair,
    output logic [7:0] idx_high,
    output logic [7:0] idx_low,
    output logic [7:0] acc,
    output logic [7:0] aux,
    output logic [15:0] acc_pair
);
    logic [7:0] regs [0:REG_BANKS*REGS_PER_BANK-1];

    // Eight bytes per bank, pair n is bytes 2n+1 and 2n
    assign rd_byte = regs[{bank, rd_code}]; // [RULE4]
    assign rd_pair = {regs[{bank, rd_pair_code, 1'b1}], regs[{bank, rd_pair_code, 1'b0}]}; // [RULE4]
    assign base_pair = {regs[{bank, PAIR_HL, 1'b1}], regs[{bank, PAIR_HL, 1'b0}]};
    assign idx_high = regs[{bank, REG_B}];
    assign idx_low = regs[{bank, REG_C}];
    assign acc = regs[{bank, REG_A}];
    assign aux = regs[{bank, REG_X}];
    assign acc_pair = {regs[{bank, PAIR_ACC, 1'b1}], regs[{bank, PAIR_ACC, 1'b0}]};

    // Storage update
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < REG_BANKS*REGS_PER_BANK; i++) begin
                regs[i] <= REG_RESET;
            end
        end else begin
            if (byte_wr_en) begin
                regs[{bank, byte_wr_code}] <= byte_wr_data;
            end
            if (pair_wr_en) begin
                regs[{bank, pair_wr_code, 1'b1}] <= pair_wr_data[15:8];
                regs[{bank, pair_wr_code, 1'b0}] <= pair_wr_data[7:0];
            end
        end
    end
endmodule

// ==== tb/oag_mem_model.sv ====
// Behavioural model of the internal memory and special register space
`timescale 1ns/100ps
module oag_mem_model (
    // Clock
    input wire logic clk_sys,
    // Access from the address generator
    input wire logic ea_valid,
    input wire logic [15:0] ea,
    input wire logic ea_word,
    // Read data, scrambled while idle
    output logic [15:0] rdata
);
    logic [7:0] mem [65536];
    logic [15:0] ea_next;
    // Fill with an address derived pattern
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = i[7:0] ^ i[15:8];
        end
        rdata = 16'h0000;
    end
    // Second byte of a pair sits at the next address
    assign ea_next = ea + 16'h0001;
    // Byte or pair read, idle data inverts every cycle
    always @(posedge clk_sys) begin
        if (ea_valid) begin
            rdata <= {ea_word ? mem[ea_next] : 8'h00, mem[ea]};
        end else begin
            rdata <= ~rdata;
        end
    end
endmodule

// ==== tb/operand_address_generator_test.sv ====
// Self-checking bench for the operand address generator
`timescale 1ns/100ps
module operand_address_generator_test import oag_pkg::*;;
    logic clk_sys = 0, reset = 1, bsl = 0, bsh = 0, req_valid = 0, req_word = 0, ih = 0, op_valid = 0;
    logic bwe = 0, pwe = 0, ea_valid, ea_word, area_hiram, area_sfr, range_err, align_err, stack_ram_err;
    logic op_hit, mul_done;
    oag_mode_e mode = MODE_REGISTER;
    logic [7:0] imm8 = 8'h00, op_byte = 8'h00, bwd = 8'h00, rd_byte;
    logic [15:0] fao = 16'h0000, sp = 16'hfe80, pwd = 16'h0000, ea, rd_pair, rdata;
    logic [2:0] rc = 3'h0, bwc = 3'h0;
    logic [1:0] pc = 2'h0, pwc = 2'h0;
    int error_cnt = 0, num_checks = 0, seed = 57591;
    logic [7:0] regs [4][8];
    logic [15:0] spt [4] = '{16'hfe80, 16'hfe11, 16'hff00, 16'hfe20};
    logic [7:0] ops [4] = '{8'h85, 8'hab, 8'hb5, 8'h00};

    // Clock at 50 MHz
    always #10 clk_sys = ~clk_sys;

    oag_addr_gen uut (.clk_sys(clk_sys), .reset(reset), .bank_select_bit_low(bsl), .bank_select_bit_high(bsh),
        .req_valid(req_valid), .req_mode(mode), .req_word(req_word), .imm8(imm8), .full_address_operand(fao),
        .reg_code(rc), .pair_code(pc), .index_high_sel(ih), .op_valid(op_valid), .op_byte(op_byte),
        .stack_pointer(sp), .byte_wr_en(bwe), .byte_wr_code(bwc), .byte_wr_data(bwd), .pair_wr_en(pwe),
        .pair_wr_code(pwc), .pair_wr_data(pwd), .ea_valid(ea_valid), .ea(ea), .ea_word(ea_word),
        .area_hiram(area_hiram), .area_sfr(area_sfr), .range_err(range_err), .align_err(align_err),
        .stack_ram_err(stack_ram_err), .rd_byte(rd_byte), .rd_pair(rd_pair), .op_hit(op_hit), .mul_done(mul_done));

    oag_mem_model mem (.clk_sys(clk_sys), .ea_valid(ea_valid), .ea(ea), .ea_word(ea_word), .rdata(rdata));

    // Value and flag comparisons
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chkf(input logic [6:0] got, input logic [6:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t flags got %h exp %h", $time, got, exp);
        end
    endtask

    // Register pair from the bench mirror, high byte is the odd register
    function automatic logic [15:0] pr(input logic [1:0] b, input logic [1:0] p);
        return {regs[b][{p, 1'b1}], regs[b][{p, 1'b0}]};
    endfunction
    // Expected flag vector for one request
    function automatic logic [6:0] flg(input logic v, w, input logic [15:0] a, input logic re, ae, se);
        return {v, v & w, v && a >= 16'hfe20 && a <= 16'hfeff, v && a >= 16'hff00, re, ae, se};
    endfunction

    // One request or opcode, answer seen one cycle later
    task automatic go(input logic o, v, input logic [15:0] a, input logic re, ae, se);
        req_valid = !o;
        op_valid = o;
        @(posedge clk_sys);
        @(negedge clk_sys);
        req_valid = 0;
        op_valid = 0;
        chkf({ea_valid, ea_valid & ea_word, area_hiram, area_sfr, range_err, align_err, stack_ram_err},
            flg(v, req_word, a, re, ae, se));
        if (v) chk16(ea, a);
    endtask

    // Byte or pair write into one bank, mirrored in the bench
    task automatic wr(input logic [1:0] b, input logic p, input logic [2:0] c, input logic [15:0] d);
        {bsh, bsl} = b;
        if (p) begin
            pwe = 1;
            pwc = c[1:0];
            pwd = d;
            regs[b][{c[1:0], 1'b1}] = d[15:8];
            regs[b][{c[1:0], 1'b0}] = d[7:0];
        end else begin
            bwe = 1;
            bwc = c;
            bwd = d[7:0];
            regs[b][c] = d[7:0];
        end
        @(negedge clk_sys);
        pwe = 0;
        bwe = 0;
    endtask

    // Counts and verdict
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk_sys);
        error_cnt++;
        end_of_test();
    end

    // Main sequence
    initial begin
        int i;
        logic [1:0] b;
        logic [7:0] v;
        logic [15:0] h;
        repeat (12) @(negedge clk_sys);
        reset = 0;
        chk16(rd_pair, 16'h0000);
        for (i = 0; i < 20; i++) wr(2'(i / 5), i % 5 == 4, 3'($random(seed)), 16'($random(seed)));
        $display("test fill done");
        for (i = 0; i < 40; i++) begin
            b = 2'($random(seed));
            {bsh, bsl} = b;
            rc = 3'($random(seed));
            pc = 2'($random(seed));
            go(0, 0, 16'h0000, 0, 0, 0);
            chk16({8'h00, rd_byte}, {8'h00, regs[b][rc]});
            chk16(rd_pair, pr(b, pc));
        end
        $display("test register done");
        mode = MODE_DIRECT;
        for (i = 0; i < 10; i++) begin
            fao = 16'($random(seed));
            go(0, 1, fao, 0, 0, 0);
        end
        mode = MODE_SHORT;
        for (i = 0; i < 256; i++) begin
            v = i[7:0];
            imm8 = v;
            req_word = 1'($random(seed));
            go(0, 1, {7'h7f, v < 8'h20, v}, 0, req_word & v[0], 0);
        end
        req_word = 1;
        imm8 = 8'h30;
        go(0, 1, 16'hfe30, 0, 0, 0);
        @(negedge clk_sys);
        chk16(rdata, {8'h31 ^ 8'hfe, 8'h30 ^ 8'hfe});
        mode = MODE_SFR;
        for (i = 0; i < 256; i++) begin
            v = i[7:0];
            imm8 = v;
            req_word = 1'($random(seed));
            go(0, 1, {8'hff, v}, v[7:4] == 4'hd, req_word & v[0], 0);
        end
        req_word = 0;
        $display("test direct windows done");
        wr(2'h1, 1, 3'h3, 16'hffc0);
        for (i = 0; i < 30; i++) begin
            b = (i == 0) ? 2'h1 : 2'($random(seed));
            {bsh, bsl} = b;
            imm8 = (i == 0) ? 8'hff : 8'($random(seed));
            pc = {1'b1, 1'($random(seed))};
            ih = 1'($random(seed));
            mode = MODE_REG_IND;
            go(0, 1, pr(b, pc), 0, 0, 0);
            mode = MODE_BASED;
            go(0, 1, pr(b, 2'h3) + {8'h00, imm8}, 0, 0, 0);
            mode = MODE_BASED_IDX;
            go(0, 1, pr(b, 2'h3) + {8'h00, regs[b][ih ? 3 : 2]}, 0, 0, 0);
        end
        $display("test indirect done");
        req_word = 1;
        for (i = 0; i < 8; i++) begin
            sp = spt[i / 2];
            mode = i[0] ? MODE_POP : MODE_PUSH;
            h = i[0] ? sp : sp - 16'h0002;
            go(0, 1, h, 0, h[0], h < 16'hfe20 || h > 16'hfefe);
        end
        sp = 16'hfe80;
        $display("test stack done");
        for (i = 0; i < 4; i++) begin
            b = 2'($random(seed));
            {bsh, bsl} = b;
            op_byte = ops[i];
            req_word = (i == 2);
            h = (i == 0) ? pr(b, 2'h2) : (i == 1) ? pr(b, 2'h3) + regs[b][3] : sp - 16'h0002;
            go(1, i < 3, h, 0, 0, 0);
            chk16({15'h0000, op_hit}, {15'h0000, i < 3});
            if (i != 1 && i != 3) chk16(rd_pair, pr(b, 2'h2));
        end
        $display("test opcodes done");
        for (i = 0; i < 4; i++) begin
            b = 2'($random(seed));
            {bsh, bsl} = b;
            mode = MODE_UNSIGNED_MULTIPLY_OP;
            h = {8'h00, regs[b][1]} * {8'h00, regs[b][0]};
            go(0, 0, 16'h0000, 0, 0, 0);
            chk16({15'h0000, mul_done}, 16'h0001);
            regs[b][1] = h[15:8];
            regs[b][0] = h[7:0];
            mode = MODE_REGISTER;
            pc = 2'h0;
            go(0, 0, 16'h0000, 0, 0, 0);
            chk16(rd_pair, h);
        end
        $display("test multiply done");
        end_of_test();
    end
endmodule
